// >>> src/ifps_top.sv
// Operation
// R1: flag reads 1 after request, timers bits 3,7
// R2: flags software read/write, reset to zero
// R3: priority fields three bits, 111 is seven
// R4: 001 is lowest enabled priority, linear
// R5: priority 000 disables the source entirely; here it still sets its flag and event 1, only the arbiter skips it
// R6: priority fields writable, reset to 100
// R7: uart error priority in bits 6-4
// R8: unimplemented bits ignore writes, read zero
// R9: status bits 11-8 show new cpu level
// R10: status bits 6-0 pending vector, reset zero
// R11: small variant drops serial, capture, compare
// R12: report highest pending source above cpu level
// R13: software clears flag after servicing it
module ifps_top
    import ifps_pkg::*;
#(
    parameter bit SMALL = 1'b0
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_int_zero,
    input  wire logic [15:0] periph_req,
    output logic             irq
);
    import ifps_pkg::*;

    localparam logic [15:0] FMASK = SMALL ? IFPS_FLAG_MASK_SMALL : IFPS_FLAG_MASK_FULL;
    localparam logic [15:0] SMASK = SMALL ? IFPS_ZERO16 : IFPS_SER_MASK;
    localparam logic [15:0] UMASK = SMALL ? IFPS_ZERO16 : IFPS_LOW_MASK;

    logic [15:0] flag_q, flag_d;
    logic [15:0] ser_q, ser_d;
    logic [15:0] pwm_q, pwm_d;
    logic [15:0] uer_q, uer_d;
    logic [3:0]  cpu_q, cpu_d;
    logic [1:0]  ists_q, ists_d;
    logic [1:0]  imsk_q, imsk_d;
    logic [31:0] rdata_q, rdata_d;
    logic        rdy_q, rdy_d;
    logic        err_q, err_d;
    logic        irq_q, irq_d;
    logic        ext_s;
    logic        ext_prev_q;
    logic [15:0] req_set;
    logic [3:0]  lvl;
    logic [6:0]  vec;
    logic [3:0]  lvl_prev_q;
    logic [IFPS_NSRC-1:0]   pend;
    logic [IFPS_NSRC*3-1:0] pri;
    logic        wr_acc, rd_acc;

    // external pin is asynchronous, so it passes the synchroniser
    ifps_sync #(.W(1)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .din     (ext_int_zero),
        .dout    (ext_s)
    );

    // an access acts in its first access cycle only, since pready is low only on it
    assign wr_acc = psel && penable && !rdy_q && pwrite;
    assign rd_acc = psel && penable && !rdy_q && !pwrite;

    // request sources: peripherals are on pclk, int0 is edge taken
    always_comb begin
        req_set = periph_req & FMASK;                                        // R11
        req_set[IFPS_B_INT0] = ext_s && !ext_prev_q;
    end

    // pending sources and their priority fields, fixed order
    always_comb begin
        pend = {flag_q[IFPS_B_ADC], flag_q[IFPS_B_UTX], flag_q[IFPS_B_URX],
                flag_q[IFPS_B_SPI], flag_q[IFPS_B_SPIE], flag_q[IFPS_B_TMR2],
                flag_q[IFPS_B_TMR1], flag_q[IFPS_B_CMP1], flag_q[IFPS_B_CAP1],
                flag_q[IFPS_B_INT0]};
        // sources without a field here run at the reset priority
        pri  = {IFPS_PRI_RESET,
                uer_q[IFPS_P_LOW +: IFPS_PW],                                // R7
                ser_q[IFPS_P_URX +: IFPS_PW],
                ser_q[IFPS_P_SPI +: IFPS_PW],
                ser_q[IFPS_P_SPIE +: IFPS_PW],
                pwm_q[IFPS_P_LOW +: IFPS_PW],
                IFPS_PRI_RESET, IFPS_PRI_RESET, IFPS_PRI_RESET, IFPS_PRI_RESET};
    end

    ifps_arbiter #(.N(IFPS_NSRC)) u_arb (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .pend    (pend),
        .pri     (pri),
        .cpu_lvl (cpu_q),
        .lvl     (lvl),
        .vec     (vec)
    );

    // register writes; hardware set wins over a software clear
    always_comb begin
        flag_d = flag_q;
        ser_d  = ser_q;
        pwm_d  = pwm_q;
        uer_d  = uer_q;
        cpu_d  = cpu_q;
        imsk_d = imsk_q;
        ists_d = ists_q;
        if (wr_acc) begin
            case (paddr)
                IFPS_OFF_FLAG0:  flag_d = pwdata[15:0] & FMASK;              // R2 R8
                IFPS_OFF_SERPRI: ser_d  = pwdata[15:0] & SMASK;              // R3 R4 R6
                IFPS_OFF_PWMPRI: pwm_d  = pwdata[15:0] & IFPS_LOW_MASK;      // R6
                IFPS_OFF_UERPRI: uer_d  = pwdata[15:0] & UMASK;              // R7 R11
                IFPS_OFF_CPULVL: cpu_d  = pwdata[3:0];
                IFPS_OFF_IRQMSK: imsk_d = pwdata[1:0];
                default: ;
            endcase
        end
        if (rd_acc && paddr == IFPS_OFF_IRQSTS) begin
            ists_d = 2'b00;                                  // read clears
        end
        flag_d = flag_d | req_set;                                           // R1
        // event 0: new winner level; event 1: any request latched
        if (lvl != lvl_prev_q && lvl != 4'h0) begin
            ists_d[0] = 1'b1;
        end
        if (|req_set) begin
            ists_d[1] = 1'b1;
        end
    end

    // read mux; unmapped addresses answer with an error
    always_comb begin
        rdata_d = IFPS_ZERO32;
        err_d   = 1'b0;
        rdy_d   = psel && penable && !rdy_q;
        if (psel && penable && !rdy_q) begin
            case (paddr)
                IFPS_OFF_FLAG0:  rdata_d[15:0] = flag_q;                     // R1 R8
                IFPS_OFF_SERPRI: rdata_d[15:0] = ser_q;
                IFPS_OFF_PWMPRI: rdata_d[15:0] = pwm_q;
                IFPS_OFF_UERPRI: rdata_d[15:0] = uer_q;
                IFPS_OFF_STATUS: begin
                    rdata_d[IFPS_S_LVL +: 4] = lvl;                          // R9
                    rdata_d[IFPS_S_VEC +: 7] = vec;                          // R10
                end
                IFPS_OFF_CPULVL: rdata_d[3:0] = cpu_q;
                IFPS_OFF_IRQSTS: rdata_d[1:0] = ists_q;
                IFPS_OFF_IRQMSK: rdata_d[1:0] = imsk_q;
                default:         err_d = 1'b1;
            endcase
            if (!pwrite) begin
                rdata_d = err_d ? IFPS_ZERO32 : rdata_d;
            end else begin
                rdata_d = IFPS_ZERO32;
            end
        end
        irq_d = |(ists_d & imsk_d);
    end

    // all state, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q     <= IFPS_ZERO16;                                       // R2
            ser_q      <= SMALL ? IFPS_ZERO16 : {1'b0, IFPS_PRI_RESET, 1'b0,
                          IFPS_PRI_RESET, 1'b0, IFPS_PRI_RESET, 4'h0};       // R6
            pwm_q      <= {9'h000, IFPS_PRI_RESET, 4'h0};
            uer_q      <= SMALL ? IFPS_ZERO16 : {9'h000, IFPS_PRI_RESET, 4'h0};
            cpu_q      <= 4'h0;
            ists_q     <= 2'b00;
            imsk_q     <= 2'b00;
            rdata_q    <= IFPS_ZERO32;
            rdy_q      <= 1'b0;
            err_q      <= 1'b0;
            irq_q      <= 1'b0;
            ext_prev_q <= 1'b0;
            lvl_prev_q <= 4'h0;
        end else if (ce) begin
            flag_q     <= flag_d;
            ser_q      <= ser_d;
            pwm_q      <= pwm_d;
            uer_q      <= uer_d;
            cpu_q      <= cpu_d;
            ists_q     <= ists_d;
            imsk_q     <= imsk_d;
            rdata_q    <= rdata_d;
            rdy_q      <= rdy_d;
            err_q      <= err_d;
            irq_q      <= irq_d;
            ext_prev_q <= ext_s;
            lvl_prev_q <= lvl;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = rdy_q;
    assign pslverr = err_q;
    assign irq     = irq_q;
endmodule

// >>> src/ifps_pkg.sv
package ifps_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] IFPS_OFF_FLAG0   = 8'h00;
    localparam logic [7:0] IFPS_OFF_SERPRI  = 8'h04;
    localparam logic [7:0] IFPS_OFF_PWMPRI  = 8'h08;
    localparam logic [7:0] IFPS_OFF_UERPRI  = 8'h0C;
    localparam logic [7:0] IFPS_OFF_STATUS  = 8'h10;
    localparam logic [7:0] IFPS_OFF_CPULVL  = 8'h14;
    localparam logic [7:0] IFPS_OFF_IRQSTS  = 8'h18;
    localparam logic [7:0] IFPS_OFF_IRQMSK  = 8'h1C;

    // flag register bit positions
    localparam int IFPS_B_INT0 = 0;
    localparam int IFPS_B_CAP1 = 1;
    localparam int IFPS_B_CMP1 = 2;
    localparam int IFPS_B_TMR1 = 3;
    localparam int IFPS_B_TMR2 = 7;
    localparam int IFPS_B_SPIE = 9;
    localparam int IFPS_B_SPI  = 10;
    localparam int IFPS_B_URX  = 11;
    localparam int IFPS_B_UTX  = 12;
    localparam int IFPS_B_ADC  = 13;

    // writable masks: full part and smallest variant
    localparam logic [15:0] IFPS_FLAG_MASK_FULL  = 16'h3E8F;
    // external int0 stays in the small variant; only serial, capture, compare go
    localparam logic [15:0] IFPS_FLAG_MASK_SMALL = 16'h2089;

    // priority field positions
    localparam int IFPS_P_URX  = 12;
    localparam int IFPS_P_SPI  = 8;
    localparam int IFPS_P_SPIE = 4;
    localparam int IFPS_P_LOW  = 4;
    localparam int IFPS_PW     = 3;

    localparam logic [2:0]  IFPS_PRI_RESET = 3'h4;
    localparam logic [2:0]  IFPS_PRI_OFF   = 3'h0;
    localparam logic [15:0] IFPS_SER_MASK  = 16'h7770;
    localparam logic [15:0] IFPS_LOW_MASK  = 16'h0070;

    // status field positions
    localparam int IFPS_S_LVL = 8;
    localparam int IFPS_S_VEC = 0;
    localparam int IFPS_NSRC  = 10;
    // vector offset added to source index (arbitrary base)
    localparam logic [6:0] IFPS_VEC_BASE = 7'h08;

    localparam logic [31:0] IFPS_ZERO32 = 32'h0000_0000;
    localparam logic [15:0] IFPS_ZERO16 = 16'h0000;
endpackage

// >>> src/ifps_sync.sv
// three-stage input synchroniser, change taken when stages 2 and 3 agree
module ifps_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] out_d;

    // stage one is read only by stage two
    always_comb begin
        out_d = out_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else if (ce) begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule

// >>> src/ifps_arbiter.sv
// picks the highest-priority pending source above the cpu level
module ifps_arbiter #(
    parameter int N = 10
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           ce,
    input  wire logic [N-1:0]   pend,
    input  wire logic [N*3-1:0] pri,
    input  wire logic [3:0]     cpu_lvl,
    output logic      [3:0]     lvl,
    output logic      [6:0]     vec
);
    import ifps_pkg::*;
    logic [3:0] lvl_q, lvl_d;
    logic [6:0] vec_q, vec_d;

    // lowest index wins a tie; a disabled source never competes
    always_comb begin
        lvl_d = 4'h0;
        vec_d = 7'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i] && pri[i*3 +: 3] != IFPS_PRI_OFF                  // R5
                && {1'b0, pri[i*3 +: 3]} > cpu_lvl                       // R12
                && {1'b0, pri[i*3 +: 3]} >= lvl_d) begin
                lvl_d = {1'b0, pri[i*3 +: 3]};
                vec_d = IFPS_VEC_BASE + 7'(i);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_q <= 4'h0;
            vec_q <= 7'h00;
        end else if (ce) begin
            lvl_q <= lvl_d;
            vec_q <= vec_d;
        end
    end

    assign lvl = lvl_q;
    assign vec = vec_q;
endmodule

// >>> verif/ifps_asserts.sv
// watches the apb answer and the read-back layout of the block
module ifps_asserts
    import ifps_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // access phase still waiting for its answer
    sequence s_wait;
        ce && psel && penable && !pready;
    endsequence
    // answer cycle of a read from one offset
    sequence s_rd(logic [7:0] a);
        pready && !pwrite && paddr == a;
    endsequence

    AST_ONE_WAIT: assert property (s_wait |=> pready)
        else $error("no answer after one wait state");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_IDLE: assert property (!psel |=> !pready)
        else $error("pready without a transfer");
    AST_ERR_PAIR: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("pslverr without pready or with data");
    AST_DATA_ZERO: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer cycle");
    AST_FLAG_GAPS: assert property (s_rd(IFPS_OFF_FLAG0) |-> (prdata & 32'hFFFF_C170) == 0)
        else $error("unused flag bits read nonzero");
    AST_PRI_GAPS: assert property (s_rd(IFPS_OFF_UERPRI) |-> (prdata & 32'hFFFF_FF8F) == 0)
        else $error("uart error priority outside bits 6-4");
    AST_STS_GAPS: assert property (s_rd(IFPS_OFF_STATUS) |-> (prdata & 32'hFFFF_F080) == 0)
        else $error("status unused bits nonzero");
    AST_VEC_IDLE: assert property (pready && !pwrite && paddr == IFPS_OFF_STATUS &&
        prdata[11:8] == 4'h0 |-> prdata[6:0] == 7'h00)
        else $error("vector without a level");
endmodule

bind ifps_top ifps_asserts u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

// >>> verif/ifps_periph.sv
// peripherals raising requests on the shared clock, plus the external pin
module ifps_periph (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [15:0] kick,
    input wire logic        pin,
    output logic     [15:0] periph_req,
    output logic            ext_int_zero
);
    timeunit 1ns;
    timeprecision 1ps;
    // requests are registered so they never change on the sampling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) periph_req <= 16'h0000;
        else periph_req <= kick;
    end
    // pin is asynchronous to the block; the bench decides its width
    assign ext_int_zero = pin;
endmodule

// >>> verif/interrupt_flag_priority_status_tb.sv
module interrupt_flag_priority_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ifps_pkg::*;
    localparam int FB [10] = '{0, 1, 2, 3, 7, 9, 10, 11, 12, 13};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e, pin, ext, ce;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] kick, req, f, s, p, u;
    logic [3:0]  c;
    int          n_errors, n_tests;

    ifps_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_int_zero(ext), .periph_req(req), .irq(irq));
    ifps_periph u_per (.pclk(pclk), .presetn(presetn), .kick(kick), .pin(pin),
        .periph_req(req), .ext_int_zero(ext));

    // expected level and vector: strict compare keeps the lowest index on ties
    function automatic logic [15:0] exp_sts(input logic [15:0] fl, sp, pp, up,
                                            input logic [3:0] cl);
        logic [2:0] pr [10];
        logic [3:0] lv;
        logic [6:0] v;
        pr = '{3'h4, 3'h4, 3'h4, 3'h4, pp[6:4], sp[6:4], sp[10:8], sp[14:12], up[6:4], 3'h4};
        lv = cl;
        v = 7'h00;
        for (int i = 0; i < 10; i++) begin
            if (fl[FB[i]] && {1'b0, pr[i]} > lv) begin
                lv = {1'b0, pr[i]};
                v = IFPS_VEC_BASE + 7'(i);
            end
        end
        return (v == 7'h00) ? 16'h0000 : {4'h0, lv, 1'b0, v};
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, x);
        end
    endtask

    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        r = prdata;
        e = pslverr;
        if (n >= 40) begin
            n_errors++;
            $display("[FAIL] %0t no pready within bound", $time);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic close_out;
        if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // hang guard, far beyond the expected run
    initial begin
        #200000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out;
    end

    initial begin
        {presetn, psel, penable, pwrite, pin} = '0;
        ce = 1'b1;
        paddr = '0;
        pwdata = '0;
        kick = '0;
        n_errors = 0;
        n_tests = 0;
        void'($urandom(32'h03ee));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, IFPS_OFF_FLAG0, 0);  chk(r, 32'h0000_0000);
        apb(0, IFPS_OFF_SERPRI, 0); chk(r, 32'h0000_4440);
        apb(0, IFPS_OFF_PWMPRI, 0); chk(r, 32'h0000_0040);
        apb(0, IFPS_OFF_UERPRI, 0); chk(r, 32'h0000_0040);
        apb(0, IFPS_OFF_STATUS, 0); chk(r, 32'h0000_0000);
        apb(1, IFPS_OFF_FLAG0, '1); apb(0, IFPS_OFF_FLAG0, 0); chk(r, 32'h0000_3E8F);
        apb(1, IFPS_OFF_UERPRI, '1); apb(0, IFPS_OFF_UERPRI, 0); chk(r, 32'h0000_0070);
        apb(1, 8'h20, '1); chk({31'h0, e}, 1);
        apb(0, 8'h20, 0); chk({r[31:1], e}, 1);
        // random sources, priorities and cpu level; first two are corners
        for (int k = 0; k < 24; k++) begin
            f = 16'($urandom) & IFPS_FLAG_MASK_FULL;
            s = 16'($urandom);
            p = 16'($urandom);
            u = 16'($urandom);
            c = 4'($urandom % 8);
            if (k == 0) {f, s, p, u, c} = {16'h1E80, 52'h0};
            if (k == 1) {s, p, u, c} = {48'hFFFF_FFFF_FFFF, 4'h0};
            apb(1, IFPS_OFF_FLAG0, {16'h0, f});
            apb(1, IFPS_OFF_SERPRI, {16'h0, s});
            apb(1, IFPS_OFF_PWMPRI, {16'h0, p});
            apb(1, IFPS_OFF_UERPRI, {16'h0, u});
            apb(1, IFPS_OFF_CPULVL, {28'h0, c});
            repeat (4) @(posedge pclk);
            apb(0, IFPS_OFF_STATUS, 0); chk(r, {16'h0, exp_sts(f, s, p, u, c)});
            apb(0, IFPS_OFF_SERPRI, 0); chk(r, {16'h0, s & IFPS_SER_MASK});
        end
        apb(1, IFPS_OFF_FLAG0, 0);
        // level 0 and a cleared event register so the winner event is fresh
        apb(1, IFPS_OFF_CPULVL, 0);
        apb(0, IFPS_OFF_IRQSTS, 0);
        kick <= 16'h0088;
        @(posedge pclk);
        kick <= 16'h0000;
        pin <= 1'b1;
        repeat (6) @(posedge pclk);
        pin <= 1'b0;
        apb(0, IFPS_OFF_FLAG0, 0); chk(r, 32'h0000_0089);
        chk({31'h0, irq}, 0);
        apb(1, IFPS_OFF_IRQMSK, 3);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 1);
        apb(1, IFPS_OFF_FLAG0, 0);
        repeat (4) @(posedge pclk);
        apb(0, IFPS_OFF_IRQSTS, 0); chk(r & 3, 3);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 0);
        apb(0, IFPS_OFF_IRQSTS, 0); chk(r, 0);
        // a request while ce is low must leave no trace in the flags
        ce <= 1'b0;
        kick <= 16'h0008;
        @(posedge pclk);
        kick <= 16'h0000;
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
        apb(0, IFPS_OFF_FLAG0, 0); chk(r, 32'h0000_0000);
        close_out;
    end
endmodule
